// ==== src/pfst_defines.svh ====
// Purpose: Constants for the program-flow, stack and table-read unit.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef PFST_DEFINES_SVH
`define PFST_DEFINES_SVH
`define PFST_STACK_DEPTH 4
`define PFST_PC_W 12
`define PFST_WORD_W 16
`define PFST_RESET_VECTOR 12'h000
`define PFST_LAST_PAGE 4'hf
`define PFST_SER_BITS 16
`endif

// ==== src/pfst_pkg.sv ====
// Purpose: Types for the program-flow, stack and table-read unit.
// Assumes: Nothing beyond the defines header.
// Notes: Opcode codes follow declaration order.
package pfst_pkg;
  typedef enum logic [4:0] {
    PFST_OP_NOP, PFST_OP_ADD, PFST_OP_ADC, PFST_OP_SUB, PFST_OP_SBC, PFST_OP_DAA,
    PFST_OP_AND, PFST_OP_OR, PFST_OP_XOR, PFST_OP_CPL, PFST_OP_RR, PFST_OP_RRC,
    PFST_OP_RL, PFST_OP_RLC, PFST_OP_INC, PFST_OP_DEC, PFST_OP_SZ, PFST_OP_SNZ,
    PFST_OP_SIZ, PFST_OP_SDZ
  } pfst_alu_op_e;
  typedef enum logic [2:0] {
    PFST_FL_NONE, PFST_FL_JMP, PFST_FL_CALL, PFST_FL_RET, PFST_FL_TABRD, PFST_FL_TABRDL
  } pfst_flow_e;
  typedef enum {PFST_S_RUN, PFST_S_FILL, PFST_S_TAB} pfst_state_e;
endpackage : pfst_pkg

// ==== src/pfst_core.sv ====
// Purpose: Program flow unit: program counter, four-level return stack, table reads,
//          ALU and serial in-circuit programming port over a 4K x 16 program memory.
// Assumes: SYS_CLK is the instruction-cycle clock; instruction decode is done outside.
// Notes: Serial programming uses a simple 16-bit shift format of our own.
//
// Operation
// - Four-level stack holds only program counter values; no software access.
// - Call or interrupt acknowledge pushes the program counter and advances the pointer.
// - Return reloads the program counter from the newest entry and pops one level.
// - After reset the stack pointer marks an empty stack.
// - Stack full holds interrupt pending until a return frees a level.
// - Call on full stack still runs, dropping the oldest saved address.
// - ALU writes the result to the chosen destination and updates status flags.
// - ALU does add, subtract, decimal adjust, logic, rotates, inc, dec, skips.
// - Program memory is 4K by 16, fetched by program counter and table reads.
// - Reset loads the program counter with the reset vector.
// - Paged table read addresses by both pointers, splits word into two bytes.
// - Unimplemented high-byte bits read as zero after every table read.
// - Last-page table read ignores the high pointer and uses the last page.
// - Table high byte changes only by a table read.
// - Every table read takes two instruction cycles.
// - Programming moves memory contents serially over one data line and a clock.
// - Instructions that change the program counter take one extra cycle.
`timescale 1ns/100ps
`include "pfst_defines.svh"
module pfst_core
  import pfst_pkg::*;
#(
  parameter int DEPTH = `PFST_STACK_DEPTH,
  parameter int PC_W = `PFST_PC_W,
  parameter int WORD_W = `PFST_WORD_W,
  parameter int HIGH_W = 8
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic INSTR_VALID,
  input wire pfst_flow_e FLOW_OP,
  input wire logic [PC_W-1:0] FLOW_TARGET,
  input wire logic INT_REQ,
  input wire logic [PC_W-1:0] INT_VECTOR,
  input wire logic [7:0] TABLE_PTR_LOW,
  input wire logic [7:0] TABLE_PTR_HIGH,
  input wire pfst_alu_op_e ALU_OP,
  input wire logic [7:0] ALU_A,
  input wire logic [7:0] ALU_B,
  input wire logic [3:0] ALU_DEST_IN,
  input wire logic CARRY_IN,
  input wire logic PROG_SERIAL_CLOCK_LINE,
  input wire logic PROG_SERIAL_DATA_LINE_IN,
  input wire logic PROG_MODE,
  output logic PROG_SERIAL_DATA_LINE_OUT,
  output logic PROG_SERIAL_DATA_LINE_OE,
  output logic [PC_W-1:0] PC,
  output logic [WORD_W-1:0] INSTR_WORD,
  output logic STALL,
  output logic INT_ACK,
  output logic INT_PENDING,
  output logic [7:0] TABLE_DATA_LOW,
  output logic [7:0] TABLE_HIGH_BYTE,
  output logic TABLE_DONE,
  output logic [7:0] ALU_RESULT,
  output logic [3:0] ALU_DEST,
  output logic ALU_CARRY,
  output logic ALU_ZERO,
  output logic ALU_SKIP,
  output logic [1:0] STACK_LEVEL
);
  localparam int SP_W = $clog2(DEPTH + 1);
  localparam int MEM_N = 1 << PC_W;
  localparam logic [SP_W-1:0] FULL = SP_W'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // Program memory, written only by the serial port.
  logic [WORD_W-1:0] prog_mem [MEM_N];
  logic [PC_W-1:0] stack_mem [DEPTH];
  logic [PC_W-1:0] next_stack_mem [DEPTH];
  logic [SP_W-1:0] sp, next_sp;
  logic [PC_W-1:0] pc_reg, next_pc;
  logic [PC_W-1:0] tab_addr, next_tab_addr;
  pfst_state_e state, next_state;
  logic next_stall, next_int_ack, next_int_pending, next_tab_done;
  logic [7:0] next_tab_low, next_tab_high;
  logic [WORD_W-1:0] fetch_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Flow control and stack.
  always_comb
  begin
    next_stack_mem = stack_mem;
    next_sp = sp;
    next_pc = pc_reg;
    next_state = state;
    next_stall = 1'b0;
    next_int_ack = 1'b0;
    next_int_pending = INT_PENDING | INT_REQ;
    next_tab_done = 1'b0;
    next_tab_low = TABLE_DATA_LOW;
    next_tab_high = TABLE_HIGH_BYTE;
    next_tab_addr = tab_addr;
    case (state)
      PFST_S_RUN:
      begin
        if (next_int_pending && sp != FULL)
        begin
          next_stack_mem[sp[SP_W-2:0]] = pc_reg;
          next_sp = sp + 1'b1;
          next_pc = INT_VECTOR;
          next_int_ack = 1'b1;
          next_int_pending = 1'b0;
          next_stall = 1'b1;
          next_state = PFST_S_FILL;
        end
        else if (INSTR_VALID)
        begin
          case (FLOW_OP)
            PFST_FL_JMP:
            begin
              next_pc = FLOW_TARGET;
              next_stall = 1'b1;
              next_state = PFST_S_FILL;
            end
            PFST_FL_CALL:
            begin
              if (sp == FULL)
              begin
                for (int i = 0; i < DEPTH - 1; i++)
                begin
                  next_stack_mem[i] = stack_mem[i + 1];
                end
                next_stack_mem[DEPTH-1] = pc_reg + 1'b1;
              end
              else
              begin
                next_stack_mem[sp[SP_W-2:0]] = pc_reg + 1'b1;
                next_sp = sp + 1'b1;
              end
              next_pc = FLOW_TARGET;
              next_stall = 1'b1;
              next_state = PFST_S_FILL;
            end
            PFST_FL_RET:
            begin
              if (sp == '0)
              begin
                next_pc = stack_mem[0];
              end
              else
              begin
                next_pc = stack_mem[sp[SP_W-2:0] - 1'b1];
                next_sp = sp - 1'b1;
              end
              next_stall = 1'b1;
              next_state = PFST_S_FILL;
            end
            PFST_FL_TABRD, PFST_FL_TABRDL:
            begin
              if (FLOW_OP == PFST_FL_TABRDL)
              begin
                next_tab_addr = {`PFST_LAST_PAGE, TABLE_PTR_LOW};
              end
              else
              begin
                next_tab_addr = PC_W'({TABLE_PTR_HIGH, TABLE_PTR_LOW});
              end
              next_stall = 1'b1;
              next_state = PFST_S_TAB;
            end
            default:
            begin
              next_pc = pc_reg + 1'b1;
            end
          endcase
        end
      end
      PFST_S_FILL:
      begin
        next_state = PFST_S_RUN;
      end
      PFST_S_TAB:
      begin
        next_tab_low = fetch_word[7:0];
        next_tab_high = 8'h00;
        next_tab_high[HIGH_W-1:0] = fetch_word[WORD_W-1 -: HIGH_W];
        next_tab_done = 1'b1;
        next_pc = pc_reg + 1'b1;
        next_state = PFST_S_RUN;
      end
      default:
      begin
        next_state = PFST_S_RUN;
      end
    endcase
  end

  assign fetch_word = prog_mem[tab_addr];

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sp <= '0;
      pc_reg <= `PFST_RESET_VECTOR;
      state <= PFST_S_RUN;
      STALL <= 1'b0;
      INT_ACK <= 1'b0;
      INT_PENDING <= 1'b0;
      TABLE_DONE <= 1'b0;
      TABLE_DATA_LOW <= 8'h00;
      TABLE_HIGH_BYTE <= 8'h00;
      tab_addr <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        stack_mem[i] <= '0;
      end
    end
    else if (CE)
    begin
      sp <= next_sp;
      pc_reg <= next_pc;
      state <= next_state;
      STALL <= next_stall;
      INT_ACK <= next_int_ack;
      INT_PENDING <= next_int_pending;
      TABLE_DONE <= next_tab_done;
      TABLE_DATA_LOW <= next_tab_low;
      TABLE_HIGH_BYTE <= next_tab_high;
      tab_addr <= next_tab_addr;
      stack_mem <= next_stack_mem;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      PC <= `PFST_RESET_VECTOR;
      INSTR_WORD <= '0;
      STACK_LEVEL <= 2'h0;
    end
    else if (CE)
    begin
      PC <= next_pc;
      INSTR_WORD <= prog_mem[next_pc];
      STACK_LEVEL <= (next_sp == '0) ? 2'h0 : 2'(next_sp - 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ALU.
  logic [7:0] next_res;
  logic [3:0] next_dest;
  logic next_c, next_skip;
  logic [8:0] sum;
  always_comb
  begin
    sum = 9'h000;
    next_res = 8'h00;
    next_c = CARRY_IN;
    next_skip = 1'b0;
    next_dest = ALU_DEST_IN;
    case (ALU_OP)
      PFST_OP_ADD: sum = {1'b0, ALU_A} + {1'b0, ALU_B};
      PFST_OP_ADC: sum = {1'b0, ALU_A} + {1'b0, ALU_B} + {8'h00, CARRY_IN};
      PFST_OP_SUB: sum = {1'b0, ALU_A} + {1'b0, ~ALU_B} + 9'h001;
      PFST_OP_SBC: sum = {1'b0, ALU_A} + {1'b0, ~ALU_B} + {8'h00, CARRY_IN};
      PFST_OP_DAA:
      begin
        sum = {1'b0, ALU_A};
        if (sum[3:0] > 4'h9)
        begin
          sum = sum + 9'h006;
        end
        if (sum[8:4] > 5'h09 || CARRY_IN)
        begin
          sum = sum + 9'h060;
        end
      end
      default: sum = 9'h000;
    endcase
    case (ALU_OP)
      PFST_OP_ADD, PFST_OP_ADC, PFST_OP_SUB, PFST_OP_SBC, PFST_OP_DAA:
      begin
        next_res = sum[7:0];
        next_c = sum[8];
      end
      PFST_OP_AND: next_res = ALU_A & ALU_B;
      PFST_OP_OR: next_res = ALU_A | ALU_B;
      PFST_OP_XOR: next_res = ALU_A ^ ALU_B;
      PFST_OP_CPL: next_res = ~ALU_A;
      PFST_OP_RR: next_res = {ALU_A[0], ALU_A[7:1]};
      PFST_OP_RL: next_res = {ALU_A[6:0], ALU_A[7]};
      PFST_OP_RRC:
      begin
        next_res = {CARRY_IN, ALU_A[7:1]};
        next_c = ALU_A[0];
      end
      PFST_OP_RLC:
      begin
        next_res = {ALU_A[6:0], CARRY_IN};
        next_c = ALU_A[7];
      end
      PFST_OP_INC: next_res = ALU_A + 8'h01;
      PFST_OP_DEC: next_res = ALU_A - 8'h01;
      PFST_OP_SZ:
      begin
        next_res = ALU_A;
        next_skip = (ALU_A == 8'h00);
      end
      PFST_OP_SNZ:
      begin
        next_res = ALU_A;
        next_skip = (ALU_A != 8'h00);
      end
      PFST_OP_SIZ:
      begin
        next_res = ALU_A + 8'h01;
        next_skip = (next_res == 8'h00);
      end
      PFST_OP_SDZ:
      begin
        next_res = ALU_A - 8'h01;
        next_skip = (next_res == 8'h00);
      end
      default: next_res = ALU_A;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ALU_RESULT <= 8'h00;
      ALU_DEST <= 4'h0;
      ALU_CARRY <= 1'b0;
      ALU_ZERO <= 1'b0;
      ALU_SKIP <= 1'b0;
    end
    else if (CE)
    begin
      ALU_RESULT <= next_res;
      ALU_DEST <= next_dest;
      ALU_CARRY <= next_c;
      ALU_ZERO <= (next_res == 8'h00);
      ALU_SKIP <= next_skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial programming port; both lines are pins and are synchronised first.
  logic [2:0] ck_sync, next_ck_sync;
  logic [1:0] da_sync, next_da_sync;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [WORD_W-1:0] shreg, next_shreg;
  logic [PC_W-1:0] prog_addr, next_prog_addr;
  logic next_da_out, next_da_oe, wr_en;
  always_comb
  begin
    next_ck_sync = {ck_sync[1:0], PROG_SERIAL_CLOCK_LINE};
    next_da_sync = {da_sync[0], PROG_SERIAL_DATA_LINE_IN};
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_prog_addr = prog_addr;
    next_da_out = PROG_SERIAL_DATA_LINE_OUT;
    next_da_oe = 1'b0;
    wr_en = 1'b0;
    if (!PROG_MODE)
    begin
      next_bit_cnt = 5'h00;
      next_prog_addr = '0;
      next_shreg = prog_mem[0];
    end
    else if (ck_sync[2:1] == 2'b01)
    begin
      // Each rising clock shifts in a bit while the old word shifts out for readback.
      next_shreg = {shreg[WORD_W-2:0], da_sync[1]};
      next_da_out = shreg[WORD_W-1];
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(`PFST_SER_BITS - 1))
      begin
        wr_en = 1'b1;
        next_bit_cnt = 5'h00;
        next_prog_addr = prog_addr + 1'b1;
        next_shreg = prog_mem[PC_W'(prog_addr + 1'b1)];
      end
    end
    if (PROG_MODE)
    begin
      next_da_oe = (ck_sync[2:1] == 2'b10) ? 1'b0 : PROG_SERIAL_DATA_LINE_OE | (ck_sync[2:1] == 2'b01);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ck_sync <= 3'h0;
      da_sync <= 2'h0;
      bit_cnt <= 5'h00;
      shreg <= '0;
      prog_addr <= '0;
      PROG_SERIAL_DATA_LINE_OUT <= 1'b0;
      PROG_SERIAL_DATA_LINE_OE <= 1'b0;
    end
    else if (CE)
    begin
      ck_sync <= next_ck_sync;
      da_sync <= next_da_sync;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      prog_addr <= next_prog_addr;
      PROG_SERIAL_DATA_LINE_OUT <= next_da_out;
      PROG_SERIAL_DATA_LINE_OE <= next_da_oe;
      if (wr_en)
      begin
        prog_mem[prog_addr] <= {shreg[WORD_W-2:0], da_sync[1]};
      end
    end
  end
endmodule : pfst_core

// ==== verif/pfst_core_sva.sv ====
// Purpose: Port assertions for the program flow unit.
// Assumes: One clock domain, synchronous active-high reset, CE held high by the bench.
// Notes: Instruction acceptance is judged from the ports, so fill and table cycles are excluded.
`timescale 1ns/100ps
module pfst_core_sva
  import pfst_pkg::*;
#(
  parameter int PC_W = 12
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic INSTR_VALID,
  input wire pfst_flow_e FLOW_OP,
  input wire logic [PC_W-1:0] FLOW_TARGET,
  input wire logic [PC_W-1:0] INT_VECTOR,
  input wire pfst_alu_op_e ALU_OP,
  input wire logic [7:0] ALU_A,
  input wire logic [7:0] ALU_B,
  input wire logic [3:0] ALU_DEST_IN,
  input wire logic PROG_MODE,
  input wire logic PROG_SERIAL_DATA_LINE_OE,
  input wire logic [PC_W-1:0] PC,
  input wire logic STALL,
  input wire logic INT_ACK,
  input wire logic INT_PENDING,
  input wire logic [7:0] TABLE_HIGH_BYTE,
  input wire logic TABLE_DONE,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [3:0] ALU_DEST,
  input wire logic ALU_CARRY,
  input wire logic ALU_ZERO,
  input wire logic [1:0] STACK_LEVEL
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  sequence taken_s(f);
    CE && INSTR_VALID && FLOW_OP == f && !STALL && !$past(STALL) && !INT_PENDING && !INT_ACK;
  endsequence
  sequence fill_s;
    STALL ##1 !STALL;
  endsequence
  AST_RESET_STATE: assert property ($fell(RST) |-> PC == '0 && STACK_LEVEL == 2'h0)
    else $error("state after reset is not empty stack at vector");
  AST_CALL_PC: assert property (taken_s(PFST_FL_CALL) |=> PC == $past(FLOW_TARGET) && STALL)
    else $error("call did not load target with a fill cycle");
  AST_JMP_FILL: assert property (taken_s(PFST_FL_JMP) |=> fill_s)
    else $error("jump fill cycle is not exactly one cycle");
  AST_FULL_CALL: assert property (taken_s(PFST_FL_CALL) ##0 STACK_LEVEL == 2'h3 |=> STACK_LEVEL == 2'h3)
    else $error("call on full stack changed the level");
  AST_RET_POP: assert property (taken_s(PFST_FL_RET) ##0 STACK_LEVEL != 2'h0
    |=> STACK_LEVEL == $past(STACK_LEVEL) - 2'h1 && STALL)
    else $error("return did not pop one level");
  AST_RET_EMPTY: assert property (taken_s(PFST_FL_RET) ##0 STACK_LEVEL == 2'h0 |=> STACK_LEVEL == 2'h0)
    else $error("return on bottom level wrapped");
  AST_INT_HOLD: assert property (INT_PENDING && STACK_LEVEL == 2'h3 && !INSTR_VALID |=> !INT_ACK)
    else $error("interrupt acknowledged with full stack");
  AST_ACK_VEC: assert property (INT_ACK |-> ##[0:2] PC == INT_VECTOR)
    else $error("acknowledge did not reach the entry address");
  AST_TAB_TWO: assert property ((taken_s(PFST_FL_TABRD) or taken_s(PFST_FL_TABRDL)) |=> STALL ##1 TABLE_DONE)
    else $error("table read did not finish in two cycles");
  AST_TABLE_HIGH_BYTE_HOLD: assert property ($changed(TABLE_HIGH_BYTE) && !$past(RST) |-> TABLE_DONE)
    else $error("table high byte changed without a table read");
  AST_ALU_ADD: assert property (CE && ALU_OP == PFST_OP_ADD |=> ALU_RESULT == 8'($past(ALU_A) + $past(ALU_B))
    && ALU_CARRY == ($past(ALU_A) > ~$past(ALU_B)) && ALU_DEST == $past(ALU_DEST_IN))
    else $error("add result, carry or destination wrong");
  AST_ALU_XOR: assert property (CE && ALU_OP == PFST_OP_XOR |=> ALU_RESULT == ($past(ALU_A) ^ $past(ALU_B))
    && ALU_ZERO == (ALU_RESULT == 8'h00))
    else $error("xor result or zero flag wrong");
  AST_PROG_OFF: assert property (!PROG_MODE && !$past(PROG_MODE) |-> !PROG_SERIAL_DATA_LINE_OE)
    else $error("data line driven outside programming");
endmodule : pfst_core_sva
////////////////////////////////////////////////////////////////////////////////
bind pfst_core pfst_core_sva #(.PC_W(PC_W)) chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .INSTR_VALID(INSTR_VALID),
  .FLOW_OP(FLOW_OP), .FLOW_TARGET(FLOW_TARGET), .INT_VECTOR(INT_VECTOR), .ALU_OP(ALU_OP), .ALU_A(ALU_A),
  .ALU_B(ALU_B), .ALU_DEST_IN(ALU_DEST_IN), .PROG_MODE(PROG_MODE),
  .PROG_SERIAL_DATA_LINE_OE(PROG_SERIAL_DATA_LINE_OE), .PC(PC), .STALL(STALL), .INT_ACK(INT_ACK),
  .INT_PENDING(INT_PENDING), .TABLE_HIGH_BYTE(TABLE_HIGH_BYTE), .TABLE_DONE(TABLE_DONE), .ALU_RESULT(ALU_RESULT),
  .ALU_DEST(ALU_DEST), .ALU_CARRY(ALU_CARRY), .ALU_ZERO(ALU_ZERO), .STACK_LEVEL(STACK_LEVEL));

// ==== verif/pfst_prog_model.sv ====
// Purpose: External serial programmer on the programming clock and data lines.
// Assumes: The device samples data on the rising programming clock, MSB first.
// Notes: The clock stands low between frames; released data shows the inverse of the last bit.
`timescale 1ns/100ps
module pfst_prog_model
(
  output logic clk_line,
  output logic data_line
);
  initial
  begin
    clk_line = 1'b0;
    data_line = 1'b1;
  end
  // Half periods of eight system cycles leave the two-flop synchroniser room to settle.
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      data_line = w[i];
      #32 clk_line = 1'b1;
      #32 clk_line = 1'b0;
    end
    data_line = ~w[0];
    #64;
  endtask : send_word
endmodule : pfst_prog_model

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the program flow, stack and table unit.
// Assumes: Serial words land from address 0 upward while programming mode is on.
// Notes: Table results are queued by the driver and compared by a monitor on TABLE_DONE.
`timescale 1ns/100ps
module testbench;
  import pfst_pkg::*;
  localparam logic [11:0] VEC = 12'h004;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic valid = 1'b0;
  logic int_req = 1'b0;
  logic cin = 1'b0;
  logic pmode = 1'b0;
  pfst_flow_e op = PFST_FL_NONE;
  pfst_alu_op_e aop = PFST_OP_NOP;
  logic [11:0] tgt = 12'h000;
  logic [11:0] mpc;
  logic [7:0] tlo = 8'h00;
  logic [7:0] thi = 8'h00;
  logic [7:0] a = 8'h00;
  logic [7:0] b = 8'h00;
  logic [3:0] dest = 4'h0;
  logic [8:0] s;
  logic [31:0] lfsr = 32'h91e0;
  logic [15:0] w [2];
  logic [15:0] exp_q [$];
  logic [11:0] mstk [$];
  logic pclk, pmod, pout, poe, stall, ack, pend, tdone, carry, zero, skip;
  logic [15:0] rdbk;
  logic [11:0] pc;
  logic [15:0] iword;
  logic [7:0] tlow, thigh, res;
  logic [3:0] odest;
  logic [1:0] lvl;
  int failures = 0;
  int check_count = 0;
  int ack_cnt = 0;
  int n;
  pfst_alu_op_e ops [8] = '{PFST_OP_ADD, PFST_OP_ADC, PFST_OP_SUB, PFST_OP_AND, PFST_OP_OR, PFST_OP_XOR,
    PFST_OP_SZ, PFST_OP_SNZ};
  wire pdat = poe ? pout : pmod;
  always #2 SYS_CLK = ~SYS_CLK;
  pfst_prog_model prog_u (.clk_line(pclk), .data_line(pmod));
  pfst_core dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .CE(1'b1), .INSTR_VALID(valid), .FLOW_OP(op), .FLOW_TARGET(tgt),
    .INT_REQ(int_req), .INT_VECTOR(VEC), .TABLE_PTR_LOW(tlo), .TABLE_PTR_HIGH(thi), .ALU_OP(aop), .ALU_A(a),
    .ALU_B(b), .ALU_DEST_IN(dest), .CARRY_IN(cin), .PROG_SERIAL_CLOCK_LINE(pclk), .PROG_SERIAL_DATA_LINE_IN(pdat),
    .PROG_MODE(pmode), .PROG_SERIAL_DATA_LINE_OUT(pout), .PROG_SERIAL_DATA_LINE_OE(poe), .PC(pc),
    .INSTR_WORD(iword), .STALL(stall), .INT_ACK(ack), .INT_PENDING(pend), .TABLE_DATA_LOW(tlow),
    .TABLE_HIGH_BYTE(thigh), .TABLE_DONE(tdone), .ALU_RESULT(res), .ALU_DEST(odest), .ALU_CARRY(carry),
    .ALU_ZERO(zero), .ALU_SKIP(skip), .STACK_LEVEL(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_step
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, expv);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // Holds the instruction for exactly its accepting edge, then waits out any fill cycle.
  task automatic issue(input pfst_flow_e f, input logic [11:0] t);
    op = f;
    tgt = t;
    valid = 1'b1;
    @(posedge SYS_CLK);
    #1 valid = 1'b0;
    op = PFST_FL_NONE;
    @(posedge SYS_CLK);
    #1 n = 0;
    while (stall === 1'b1 && n < 20)
    begin
      @(posedge SYS_CLK);
      #1 n++;
    end
  endtask : issue
  task automatic rst_pulse(input int cyc);
    RST = 1'b1;
    repeat (cyc) @(posedge SYS_CLK);
    #1 RST = 1'b0;
    mpc = 12'h000;
    chk(16'(pc), 16'h0000);
    chk(16'(lvl), 16'h0000);
  endtask : rst_pulse
  ////////////////////////////////////////////////////////////////////////////////
  // The line is sampled on the falling programming clock, while the device drives its readback bit.
  always @(negedge pclk)
  begin
    if (pmode)
      rdbk <= {rdbk[14:0], pdat};
  end
  always @(negedge SYS_CLK)
  begin
    if (ack === 1'b1)
      ack_cnt++;
    if (tdone === 1'b1 && exp_q.size() > 0)
      chk({thigh, tlow}, exp_q.pop_front());
  end
  initial
  begin
    #200000 failures++;
    end_sim();
  end
  initial
  begin
    rst_pulse(4);
    lfsr = lfsr_step(lfsr);
    w[0] = lfsr[15:0];
    w[1] = lfsr[31:16];
    pmode = 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1 prog_u.send_word(w[0]);
    prog_u.send_word(w[1]);
    repeat (8) @(posedge SYS_CLK);
    #1 pmode = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #1 pmode = 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1 prog_u.send_word(w[0]);
    chk(rdbk, w[0]);
    repeat (8) @(posedge SYS_CLK);
    #1 pmode = 1'b0;
    rst_pulse(2);
    repeat (3) @(posedge SYS_CLK);
    #1 chk(iword, w[0]);
    for (int i = 0; i < 2; i++)
    begin
      tlo = 8'(1 - i);
      exp_q.push_back(w[1 - i]);
      issue(PFST_FL_TABRD, 12'h000);
    end
    thi = lfsr[7:0];
    issue(PFST_FL_TABRDL, 12'h000);
    chk(16'(exp_q.size()), 16'h0000);
    issue(PFST_FL_JMP, 12'h100);
    mpc = 12'h100;
    chk(16'(pc), 16'(mpc));
    for (int i = 0; i < 5; i++)
    begin
      mstk.push_back(mpc + 12'h001);
      if (mstk.size() > 4)
        void'(mstk.pop_front());
      mpc = 12'(i + 2) << 8;
      issue(PFST_FL_CALL, mpc);
      chk(16'(pc), 16'(mpc));
      chk(16'(lvl), 16'((i < 3) ? i : 3));
    end
    for (int i = 0; i < 5; i++)
    begin
      if (i < 4)
        mpc = mstk.pop_back();
      issue(PFST_FL_RET, 12'h000);
      if (i < 4)
        chk(16'(pc), 16'(mpc));
      chk(16'(lvl), 16'((i < 3) ? 2 - i : 0));
    end
    for (int i = 0; i < 4; i++)
      issue(PFST_FL_CALL, 12'h200 + 12'(i));
    ack_cnt = 0;
    int_req = 1'b1;
    @(posedge SYS_CLK);
    #1 int_req = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #1 chk(16'(pend), 16'h0001);
    chk(16'(ack_cnt), 16'h0000);
    issue(PFST_FL_RET, 12'h000);
    n = 0;
    while (ack_cnt == 0 && n < 20)
    begin
      @(posedge SYS_CLK);
      #1 n++;
    end
    repeat (3) @(posedge SYS_CLK);
    #1 chk(16'(pc), 16'(VEC));
    chk(16'(pend), 16'h0000);
    rst_pulse(2);
    for (int i = 0; i < 24; i++)
    begin
      lfsr = lfsr_step(lfsr);
      aop = ops[int'(lfsr[7:0]) % 8];
      a = lfsr[15:8];
      b = lfsr[23:16];
      dest = lfsr[27:24];
      cin = lfsr[28];
      case (aop)
        PFST_OP_ADD: s = {1'b0, a} + {1'b0, b};
        PFST_OP_ADC: s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        PFST_OP_SUB: s = {1'b0, a - b};
        PFST_OP_AND: s = {1'b0, a & b};
        PFST_OP_OR: s = {1'b0, a | b};
        PFST_OP_SZ, PFST_OP_SNZ: s = {1'b0, a};
        default: s = {1'b0, a ^ b};
      endcase
      @(posedge SYS_CLK);
      #1 chk(16'(res), 16'(s[7:0]));
      chk(16'(odest), 16'(dest));
      chk(16'(skip), 16'((aop == PFST_OP_SZ) ? (a == 8'h00) : (aop == PFST_OP_SNZ) ? (a != 8'h00) : 1'b0));
      chk(16'(zero), 16'(s[7:0] == 8'h00));
      if (aop == PFST_OP_ADD || aop == PFST_OP_ADC)
        chk(16'(carry), 16'(s[8]));
    end
    end_sim();
  end
endmodule : testbench
